/* File: dv/lmc_ctl_model.sv */
// bus controller front end: addresses the block as talker and takes its bytes
`timescale 1ns/1ns
module lmc_ctl_model (
  // clock, reset and bench control
  input wire logic pclk, presetn, slow, talk,
  // talker side of the block
  input wire logic tx_valid, tx_eoi,
  input wire logic [7:0] tx_data,
  output logic talk_addr, tx_ready, done,
  // frame summary
  output logic [6:0] cnt,
  output logic [15:0] head
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {talk_addr, tx_ready, done, cnt, head} <= '0;
    end else begin
      done <= 1'b0;
      // slow mode stalls at random to stretch some bytes
      tx_ready <= !slow || $urandom_range(1);
      if (talk) begin
        talk_addr <= 1'b1;
        cnt <= '0;
      end
      if (tx_valid && tx_ready) begin
        cnt <= cnt + 7'h01;
        if (cnt < 2) head <= {head[7:0], tx_data};
        // addressing held until the eoi byte is in
        if (tx_eoi) begin
          talk_addr <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : lmc_ctl_model

/* File: dv/lmc_learn_limit_sva.sv */
// port assertions for the learn and limit block
`timescale 1ns/1ns
module lmc_learn_limit_sva import lmc_pkg::*; #(parameter int RD_W = RD_W_DEF) (
  // apb
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // byte streams
  input wire logic talk_addr, tx_ready, tx_valid, tx_eoi, rx_valid, rx_eoi, rx_ready,
  input wire logic [7:0] tx_data, rx_data,
  // readings and indicators
  input wire logic [1:0] rd_valid, arrow_up, arrow_dn,
  input wire logic signed [1:0][RD_W-1:0] rd_val,
  input wire logic tone_high, tone_low, ref_out_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_PRDATA: assert property (!pready |-> prdata == 0) else $error("read data outside access");
  AST_SLVERR: assert property (pready |-> pslverr == (paddr > 8'h18 || paddr[1:0] != 0))
    else $error("wrong slave error");
  AST_TALK: assert property ($rose(tx_valid) |-> talk_addr) else $error("talk unaddressed");
  AST_EOI: assert property (tx_eoi |-> tx_valid) else $error("eoi without byte");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eoi))
    else $error("byte changed before taken");
  AST_ARROW: assert property ((arrow_up & arrow_dn) == 0) else $error("both arrows");
  AST_RISE: assert property ($rose(arrow_up[0]) |-> $past(rd_valid[0], 2))
    else $error("arrow without reading");
  AST_TONEH: assert property (tone_high |-> arrow_up != 0 && $past(rd_valid, 2) != 0)
    else $error("high tone unexplained");
  AST_TONEL: assert property (tone_low |-> arrow_dn != 0 && !tone_high) else $error("low tone unexplained");
endmodule : lmc_learn_limit_sva

bind lmc_learn_limit lmc_learn_limit_sva #(.RD_W(RD_W)) u_sva (.*);

/* File: dv/tb.sv */
// self-checking bench for the learn and limit block
`timescale 1ns/1ns
module tb import lmc_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, talk = 0;
  logic rx_valid = 0, rx_eoi = 0, talk_addr, tx_ready, tx_valid, tx_eoi, rx_ready, pready, pslverr, done;
  logic tone_high, tone_low, ref_out_en;
  logic [7:0] paddr = 0, rx_data = 0, tx_data;
  logic [31:0] pwdata = 0, prdata;
  logic [1:0] rd_valid = 0, arrow_up, arrow_dn;
  logic signed [1:0][RD_W_DEF-1:0] rd_val = 0;
  logic [6:0] cnt;
  logic [15:0] head;
  logic [63:0] q[$];
  int err_count = 0, n_checks = 0, t, i;
  int v[7] = '{12000, -6000, 10000, 0, -5001, 10001, 0};
  logic [1:0] s[7] = '{1, 2, 0, 0, 2, 1, 0};
  lmc_learn_limit #(.RD_W(RD_W_DEF)) dut_u (.*);
  lmc_ctl_model u_ctl (.*);
  initial forever #50 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      chk("wait", 0, 1);
      report_and_stop;
    end
  endtask : hang
  // reads note the expected value for the watcher below
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m = 0);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back({m, d});
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 9; k++) begin
      @(posedge pclk);
      if (pready) break;
    end
    hang(pready);
    if (w) chk("slverr", pslverr, a > 8'h18);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic op(input logic [31:0] x, c);
    apb(1, A_VALUE, x);
    apb(1, A_CMD, c);
  endtask : op
  task automatic xfer(input logic [6:0] n, input logic [15:0] h);
    talk <= 1;
    @(posedge pclk);
    talk <= 0;
    for (i = 0; i < 2000 && !done; i++) @(posedge pclk);
    hang(done);
    chk("count", cnt, n);
    if (h) chk("head", head, h);
  endtask : xfer
  task automatic rdg(input int x, logic [1:0] e);
    rd_val[0] <= 24'(x);
    rd_valid <= 2'b01;
    @(posedge pclk);
    rd_valid <= 0;
    repeat (2) @(posedge pclk);
    chk("tone", {tone_high, tone_low}, e);
    @(posedge pclk);
  endtask : rdg
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      chk("prdata", prdata & q[0][63:32], q[0][31:0]);
      void'(q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h657d));
    v[3] = int'($urandom % 15000) - 5000;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // binary image: prefix, meas 1, reference output on, rest zero
    for (i = 0; i < 30; i++) begin
      rx_data <= i == 0 ? 8'h40 : i == 1 ? 8'h32 : i == 2 ? 8'h01 : i == 3 ? 8'h04 : 8'h00;
      rx_valid <= 1;
      rx_eoi <= i == 29;
      @(posedge pclk);
      hang(rx_ready);
    end
    rx_valid <= 0;
    rx_eoi <= 0;
    rx_data <= 8'hff;
    repeat (2) @(posedge pclk);
    apb(0, A_CFG, 2, 32'h3ff);
    chk("refout", ref_out_en, 1);
    $display("load test done");
    apb(1, 8'h1c, 0);
    apb(1, A_CTRL, 1);
    op(0, OP_TEXT_REQ);
    slow <= 1;
    xfer(118, 0);
    slow <= 0;
    for (t = 0; t < 2; t++) begin
      apb(1, A_CTRL, t * 2 + 1);
      op(0, OP_BIN_REQ);
      xfer(t ? 60 : 30, 16'h4032);
    end
    $display("export test done");
    op(0, OP_LINE_PICK);
    op(32'h010000, OP_CEIL);
    op(32'h80005000, OP_FLOOR);
    op(0, OP_LIM_ON);
    for (t = 0; t < 7; t++) begin
      rdg(v[t], {s[t] == 1, s[t] == 2});
      chk("arrows", {arrow_up[0], arrow_dn[0]}, {s[t] == 1, s[t] == 2});
      apb(0, A_LINE, s[t], 32'hf);
      apb(0, A_ERR, s[t] == 1 ? 21 : s[t] == 2 ? 23 : 0, 32'hff);
      apb(0, A_STATUS, s[t] ? 32'h10 : 0, 32'h10);
    end
    op(0, OP_LIM_OFF);
    rdg(12000, 0);
    apb(0, A_LINE, 0, 32'hf);
    op(1, OP_LINE_PICK);
    op(0, OP_MEAS);
    op(0, OP_LIM_ON);
    rdg(12000, 2);
    apb(0, A_LINE, 1, 32'hf);
    $display("limit test done");
    for (t = 0; t < 4; t++) begin
      op(t, OP_TRIG);
      apb(0, A_CFG, t << 4, 32'h30);
    end
    $display("trigger test done");
    repeat (2) @(posedge pclk);
    report_and_stop;
  end
endmodule : tb

/* File: verilog/lmc_byte_tx.sv */
// byte talker: walks an index over a string and hands out bytes with eoi on the last
`timescale 1ns/1ns
module lmc_byte_tx import lmc_pkg::*; #(
  parameter int LEN_W = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // string source
  input wire logic start,
  input wire logic [LEN_W-1:0] len,
  input wire logic [7:0] byte_in,
  output logic [LEN_W-1:0] idx,
  output logic busy,
  // talker side
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_eoi
);
  logic [LEN_W-1:0] len_reg;
  wire logic adv = busy && (!tx_valid || tx_ready);
  wire logic more = idx < len_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= '0;
      len_reg <= '0;
      busy <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_eoi <= 1'b0;
    end else if (start && !busy) begin
      idx <= '0;
      len_reg <= len;
      busy <= 1'b1;
    end else if (adv && more) begin
      // no gaps are forced, the string leaves as fast as the listener takes it
      tx_data <= byte_in;
      tx_valid <= 1'b1;
      tx_eoi <= (idx == len_reg - 1'b1); // see R3 // see R8
      idx <= idx + 1'b1;
    end else if (adv) begin
      tx_valid <= 1'b0;
      tx_eoi <= 1'b0;
      busy <= 1'b0; // see R11
    end
  end
endmodule : lmc_byte_tx

/* File: verilog/lmc_learn_limit.sv */
// learn-string export and import plus per-line limit checking, apb register access
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module lmc_learn_limit import lmc_pkg::*; #(
  parameter int RD_W = RD_W_DEF
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // talker, same-clock bus front end
  input wire logic talk_addr,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_eoi,
  // listener, same-clock bus front end
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_eoi,
  output logic rx_ready,
  // displayed readings, thousandths of a dB
  input wire logic [1:0] rd_valid,
  input wire logic signed [1:0][RD_W-1:0] rd_val,
  // indicators
  output logic [1:0] arrow_up,
  output logic [1:0] arrow_dn,
  output logic tone_high,
  output logic tone_low,
  output logic ref_out_en
);
  localparam int RXB = TEXT_LEN * 8;

  lmc_cfg_t cfg_reg, cfg_next;
  logic [31:0] value_reg;
  logic [1:0] ctrl_reg;
  logic [7:0] stb_reg, err_reg;
  logic pend_txt_reg, pend_bin_reg, cur_bin_reg, meas_last_reg;
  logic [RXB-1:0] rx_buf_reg;
  logic [7:0] rx_cnt_reg;
  logic rx_is_bin_reg;
  logic [1:0][1:0] stat;
  logic [1:0] over, under;
  logic [6:0] tx_idx;
  logic tx_busy;

  function automatic logic [7:0] dg(input logic [3:0] n);
    return {4'h3, n};
  endfunction : dg

  function automatic logic [7:0] sg(input logic neg);
    return neg ? CH_MINUS : CH_PLUS;
  endfunction : sg

  function automatic logic signed [RD_W-1:0] bcd_val(input logic neg, input logic [23:0] b);
    logic signed [31:0] acc;
    acc = 0;
    for (int i = 5; i >= 0; i--) begin
      acc = acc * 10 + 32'(b[i*4 +: 4]);
    end
    return RD_W'(neg ? -acc : acc);
  endfunction : bcd_val

  function automatic lmc_sens_txt_t sens_txt(input lmc_sens_t s, input lmc_lim_t l, input logic b);
    lmc_sens_txt_t t;
    t.sel = b ? "BE" : "AE";
    t.kb = "KB";
    t.cal = {dg(s.cal[15:12]), dg(s.cal[11:8]), dg(s.cal[7:4]), ".", dg(s.cal[3:0])}; // see R5
    t.en1 = "EN";
    t.os = "OS";
    t.off = {sg(s.off_neg), dg(s.off[15:12]), dg(s.off[11:8]), ".", dg(s.off[7:4]), dg(s.off[3:0])};
    t.en2 = "EN";
    t.ra = "RA";
    t.rng = dg(s.rng);
    t.en3 = "EN";
    t.fil = s.fil_man ? "FM" : "FA";
    t.fild = dg(s.fil);
    t.en4 = "EN";
    t.ll = "LL";
    t.llv = {sg(l.lo_neg), dg(l.lo[23:20]), dg(l.lo[19:16]), dg(l.lo[15:12]), ".",
             dg(l.lo[11:8]), dg(l.lo[7:4]), dg(l.lo[3:0])};
    t.en5 = "EN";
    return t;
  endfunction : sens_txt

  // fixed field order, digits only, so the whole string stays ASCII
  function automatic lmc_text_t cfg_to_text(input lmc_cfg_t c);
    lmc_text_t t;
    logic [1:0][7:0] mm;
    case (c.meas)
      3'h0: mm = "AP";
      3'h1: mm = "BP";
      3'h2: mm = "AR";
      3'h3: mm = "BR";
      3'h4: mm = "AD";
      default: mm = "BD";
    endcase
    t.tr = "TR";
    t.trigger_setting = dg({2'h0, c.trig}); // see R23
    t.meas = mm;
    t.sa = sens_txt(c.sens[0], c.lim[0], 1'b0);
    t.lh = "LH";
    t.lhv = {sg(c.lim[0].hi_neg), dg(c.lim[0].hi[23:20]), dg(c.lim[0].hi[19:16]), dg(c.lim[0].hi[15:12]),
             ".", dg(c.lim[0].hi[11:8]), dg(c.lim[0].hi[7:4]), dg(c.lim[0].hi[3:0])};
    t.en6 = "EN";
    t.sb = sens_txt(c.sens[1], c.lim[1], 1'b1);
    t.ael = c.ael ? "BE" : "AE";
    t.units = c.logu ? "LG" : "LN";
    t.oc = "OC";
    t.ocd = dg({3'h0, c.refout});
    t.gt = "GT";
    t.group_trigger_setting = dg({2'h0, c.gt});
    t.lm = "LM";
    t.lmd = dg({3'h0, c.lm_en[c.ael]});
    t.crlf = {8'h0d, 8'h0a};
    return t; // see R4
  endfunction : cfg_to_text

  function automatic lmc_sens_t txt_sens(input lmc_sens_txt_t t);
    lmc_sens_t s;
    s.cal = {t.cal[4][3:0], t.cal[3][3:0], t.cal[2][3:0], t.cal[0][3:0]};
    s.off_neg = t.off[5] == CH_MINUS;
    s.off = {t.off[4][3:0], t.off[3][3:0], t.off[1][3:0], t.off[0][3:0]};
    s.rng = t.rng[3:0];
    s.fil_man = t.fil[0] == "M";
    s.fil = t.fild[3:0];
    return s;
  endfunction : txt_sens

  function automatic logic [24:0] txt_lim(input logic [7:0][7:0] v);
    return {v[7] == CH_MINUS, v[6][3:0], v[5][3:0], v[4][3:0], v[2][3:0], v[1][3:0], v[0][3:0]};
  endfunction : txt_lim

  function automatic lmc_cfg_t text_to_cfg(input lmc_cfg_t c, input lmc_text_t t);
    lmc_cfg_t n;
    n = c;
    n.trig = t.trigger_setting[1:0];
    n.meas = {t.meas[0] == "D", t.meas[0] == "R", t.meas[1] == "B"};
    n.sens[0] = txt_sens(t.sa);
    n.sens[1] = txt_sens(t.sb);
    {n.lim[0].lo_neg, n.lim[0].lo} = txt_lim(t.sa.llv);
    {n.lim[0].hi_neg, n.lim[0].hi} = txt_lim(t.lhv);
    {n.lim[1].lo_neg, n.lim[1].lo} = txt_lim(t.sb.llv);
    n.ael = t.ael[1] == "B";
    n.logu = t.units[0] == "G";
    n.refout = t.ocd[0];
    n.gt = t.group_trigger_setting[1:0];
    n.lm_en[n.ael] = t.lmd[0];
    return n; // see R6
  endfunction : text_to_cfg

  function automatic lmc_bin_t cfg_to_bin(input lmc_cfg_t c);
    lmc_bin_t b;
    b = '0;
    b.meas = {5'h0, c.meas};
    b.flags = {c.gt, c.trig, c.rel, c.refout, c.logu, c.ael};
    b.refv = c.refv;
    for (int i = 0; i < 2; i++) begin
      b.sens[i] = {c.sens[i].cal, 7'h0, c.sens[i].off_neg, c.sens[i].off, 4'h0, c.sens[i].rng,
                   c.sens[i].fil_man, 3'h0, c.sens[i].fil};
    end
    return b; // see R9
  endfunction : cfg_to_bin

  function automatic lmc_cfg_t bin_to_cfg(input lmc_cfg_t c, input lmc_bin_t b);
    lmc_cfg_t n;
    n = c;
    n.meas = b.meas[2:0];
    {n.gt, n.trig, n.rel, n.refout, n.logu, n.ael} = b.flags;
    n.refv = b.refv;
    for (int i = 0; i < 2; i++) begin
      n.sens[i].cal = {b.sens[i].cal_hi, b.sens[i].cal_lo};
      n.sens[i].off_neg = b.sens[i].off_sign[0];
      n.sens[i].off = {b.sens[i].off_hi, b.sens[i].off_lo};
      n.sens[i].rng = b.sens[i].rng[3:0];
      n.sens[i].fil_man = b.sens[i].fil[7];
      n.sens[i].fil = b.sens[i].fil[3:0];
    end
    return n; // see R10
  endfunction : bin_to_cfg

  // apb decode, no wait states, pready and every answer come from flops loaded in the setup cycle
  wire logic setup = psel && !penable;
  wire logic acc = psel && penable && pready;
  wire logic wr = acc && pwrite;
  wire logic rd = acc && !pwrite;
  wire logic mapped = paddr <= A_CFG && paddr[1:0] == 2'h0;
  wire logic cmd_wr = wr && paddr == A_CMD && !tx_busy;
  wire lmc_op_t op = lmc_op_t'(pwdata[4:0]);
  wire logic [23:0] vbcd = value_reg[23:0];
  wire logic vneg = value_reg[VAL_NEG];
  wire logic lim_line = meas_last_reg ? cfg_reg.meas[0] : cfg_reg.ael; // see R21
  wire logic any_over = |over;
  wire logic any_under = |under;

  // outgoing strings
  wire logic [TEXT_LEN*8-1:0] txt_vec = cfg_to_text(cfg_reg);
  wire logic [BIN_FRAME*8-1:0] bin_vec = {"@2", cfg_to_bin(cfg_reg), {(BIN_LEN_LEGACY-BIN_LEN)*8{1'b0}}};
  wire logic [7:0] txt_byte = txt_vec[(TEXT_LEN-1-int'(tx_idx))*8 +: 8];
  wire logic [7:0] bin_byte = bin_vec[(BIN_FRAME-1-int'(tx_idx))*8 +: 8];
  wire logic tx_go = talk_addr && !tx_busy && (pend_txt_reg || pend_bin_reg); // see R1 // see R7
  wire logic go_bin = !pend_txt_reg;
  wire logic [6:0] bin_len = 7'(ctrl_reg[CTRL_LEGACY] ? BIN_LEN_LEGACY + 2 : BIN_LEN + 2); // see R7
  wire logic [6:0] tx_len = go_bin ? bin_len : 7'(TEXT_LEN); // see R2

  // incoming strings, complete only with the eoi byte
  wire logic rx_take = rx_valid && rx_ready;
  wire logic [RXB-1:0] rx_full = {rx_buf_reg[RXB-9:0], rx_data};
  wire logic rx_end = rx_take && rx_eoi; // see R11
  wire logic txt_load = rx_end && !rx_is_bin_reg && rx_cnt_reg == 8'(TEXT_LEN - 1);
  wire logic bin_load = rx_end && rx_is_bin_reg && rx_cnt_reg == 8'(bin_len - 1'b1);
  wire logic [BIN_LEN*8-1:0] bin_rx = ctrl_reg[CTRL_LEGACY] ?
    rx_full[(BIN_LEN_LEGACY*8)-1 -: BIN_LEN*8] : rx_full[BIN_LEN*8-1:0];

  always_comb begin
    cfg_next = cfg_reg;
    if (txt_load) begin
      cfg_next = text_to_cfg(cfg_reg, lmc_text_t'(rx_full));
    end else if (bin_load) begin
      cfg_next = bin_to_cfg(cfg_reg, lmc_bin_t'(bin_rx));
    end else if (cmd_wr) begin
      case (op)
        OP_LIM_OFF: cfg_next.lm_en[lim_line] = 1'b0; // see R13
        OP_LIM_ON: cfg_next.lm_en[lim_line] = 1'b1; // see R13 // see R15
        OP_CEIL: {cfg_next.lim[cfg_reg.ael].hi_neg, cfg_next.lim[cfg_reg.ael].hi} = {vneg, vbcd}; // see R12 // see R14
        OP_FLOOR: {cfg_next.lim[cfg_reg.ael].lo_neg, cfg_next.lim[cfg_reg.ael].lo} = {vneg, vbcd}; // see R12 // see R14
        OP_LINE_PICK: cfg_next.ael = value_reg[0];
        OP_MEAS: cfg_next.meas = value_reg[2:0];
        OP_TRIG: cfg_next.trig = value_reg[1:0];
        OP_GTRIG: cfg_next.gt = value_reg[1:0];
        OP_REF_OUT: cfg_next.refout = value_reg[0];
        OP_UNITS: cfg_next.logu = value_reg[0];
        OP_CAL: cfg_next.sens[cfg_reg.ael].cal = vbcd[15:0];
        OP_SHIFT: {cfg_next.sens[cfg_reg.ael].off_neg, cfg_next.sens[cfg_reg.ael].off} = {vneg, vbcd[15:0]};
        OP_SPAN: cfg_next.sens[cfg_reg.ael].rng = vbcd[3:0];
        OP_SMOOTH_AUTO: cfg_next.sens[cfg_reg.ael].fil_man = 1'b0;
        OP_SMOOTH_MAN: {cfg_next.sens[cfg_reg.ael].fil_man, cfg_next.sens[cfg_reg.ael].fil} = {1'b1, vbcd[3:0]};
        OP_REL: {cfg_next.rel, cfg_next.refv} = {value_reg[VAL_NEG], vbcd[15:0]};
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  wire logic [31:0] rd_mux =
    paddr == A_VALUE ? value_reg :
    paddr == A_CTRL ? {30'h0, ctrl_reg} :
    paddr == A_STATUS ? {22'h0, pend_txt_reg || pend_bin_reg, tx_busy, stb_reg} :
    paddr == A_LINE ? {28'h0, stat[1], stat[0]} :
    paddr == A_ERR ? {24'h0, err_reg} :
    paddr == A_CFG ? {22'h0, cfg_reg.lm_en, cfg_reg.gt, cfg_reg.trig, cfg_reg.meas, cfg_reg.ael} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '0;
      value_reg <= 32'h0;
      ctrl_reg <= 2'h0;
      meas_last_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      if (wr && paddr == A_VALUE) value_reg <= pwdata;
      if (wr && paddr == A_CTRL) ctrl_reg <= pwdata[1:0];
      if (cmd_wr) meas_last_reg <= op == OP_MEAS && !value_reg[1] && !value_reg[2]; // see R21
    end
  end

  // request flags; a fresh request while one waits replaces it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_txt_reg <= 1'b0;
      pend_bin_reg <= 1'b0;
      cur_bin_reg <= 1'b0;
    end else begin
      if (tx_go) cur_bin_reg <= go_bin;
      if (cmd_wr && op == OP_TEXT_REQ) begin
        pend_txt_reg <= 1'b1; // see R1
        pend_bin_reg <= 1'b0;
      end else if (cmd_wr && op == OP_BIN_REQ) begin
        pend_bin_reg <= 1'b1; // see R7
        pend_txt_reg <= 1'b0;
      end else if (tx_go) begin
        pend_txt_reg <= 1'b0;
        pend_bin_reg <= 1'b0;
      end
    end
  end

  // receive shift buffer, '@2' as the first two bytes marks a binary load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_reg <= '0;
      rx_cnt_reg <= 8'h00;
      rx_is_bin_reg <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= 1'b1;
      if (rx_take) begin
        rx_buf_reg <= rx_full;
        rx_cnt_reg <= rx_eoi ? 8'h00 : (rx_cnt_reg == 8'(TEXT_MAX) ? rx_cnt_reg : rx_cnt_reg + 8'h01);
        if (rx_eoi) rx_is_bin_reg <= 1'b0;
        else if (rx_cnt_reg == 8'h01) rx_is_bin_reg <= rx_buf_reg[7:0] == "@" && rx_data == "2";
      end
    end
  end

  // status byte and error field; a new event wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_reg <= 8'h00;
      err_reg <= 8'h00;
    end else begin
      if (any_over || any_under) stb_reg[STB_LIMIT_BIT] <= 1'b1; // see R16
      else if (rd && paddr == A_STATUS) stb_reg <= 8'h00;
      if (any_over) err_reg <= ERR_OVER; // see R17
      else if (any_under) err_reg <= ERR_UNDER; // see R17
      else if (rd && paddr == A_ERR) err_reg <= 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arrow_up <= 2'h0;
      arrow_dn <= 2'h0;
      tone_high <= 1'b0;
      tone_low <= 1'b0;
      ref_out_en <= 1'b0;
    end else begin
      arrow_up <= {stat[1] == LST_HIGH, stat[0] == LST_HIGH}; // see R19
      arrow_dn <= {stat[1] == LST_LOW, stat[0] == LST_LOW}; // see R19
      tone_high <= ctrl_reg[CTRL_SOUND] && any_over; // see R20
      tone_low <= ctrl_reg[CTRL_SOUND] && !any_over && any_under; // see R20
      ref_out_en <= cfg_reg.refout;
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_line
      lmc_limit_cmp #(.RD_W(RD_W)) u_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .en(cfg_reg.lm_en[g]),
        .rd_valid(rd_valid[g]),
        .rd_val(rd_val[g]),
        .hi(bcd_val(cfg_reg.lim[g].hi_neg, cfg_reg.lim[g].hi)),
        .lo(bcd_val(cfg_reg.lim[g].lo_neg, cfg_reg.lim[g].lo)),
        .stat(stat[g]),
        .over(over[g]),
        .under(under[g])
      );
    end
  endgenerate

  lmc_byte_tx #(.LEN_W(7)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .start(tx_go),
    .len(tx_len),
    .byte_in(cur_bin_reg ? bin_byte : txt_byte),
    .idx(tx_idx),
    .busy(tx_busy),
    .tx_ready(tx_ready),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_eoi(tx_eoi)
  );
endmodule : lmc_learn_limit

/* File: verilog/lmc_limit_cmp.sv */
// one display line's limit comparator
`timescale 1ns/1ns
module lmc_limit_cmp import lmc_pkg::*; #(
  parameter int RD_W = RD_W_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // limits and reading
  input wire logic en,
  input wire logic rd_valid,
  input wire logic signed [RD_W-1:0] rd_val,
  input wire logic signed [RD_W-1:0] hi,
  input wire logic signed [RD_W-1:0] lo,
  // result
  output logic [1:0] stat,
  output logic over,
  output logic under
);
  wire logic is_over = rd_val > hi;
  wire logic is_under = rd_val < lo;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= LST_OK;
      over <= 1'b0;
      under <= 1'b0;
    end else begin
      over <= en && rd_valid && is_over;
      under <= en && rd_valid && !is_over && is_under;
      if (!en) begin
        stat <= LST_OK; // see R13
      end else if (rd_valid) begin
        stat <= is_over ? LST_HIGH : (is_under ? LST_LOW : LST_OK); // see R18 // see R22
      end
    end
  end
endmodule : lmc_limit_cmp

/* File: verilog/lmc_pkg.sv */
// constants, command codes and learn-string layouts for the learn and limit block
// Function
// R1 - text learn request queues the string; sent at the next talk addressing
// R2 - text learn string is ASCII only and no longer than 128 characters
// R3 - eoi accompanies the last text character and no earlier one
// R4 - text fields follow the fixed trigger-to-end-marker order
// R5 - numbers use fixed digit formats, each followed by the value terminator
// R6 - a returned text learn string restores every setting it describes
// R7 - binary request sends '@','2' then 28 bytes, 58 in legacy mode
// R8 - eoi accompanies the last binary byte only
// R9 - binary image holds measurement, rel, reference, units and per-sensor settings
// R10 - binary load prefix plus bytes reconfigures the device
// R11 - transfers run unbroken; nothing counts as finished before the eoi byte
// R12 - limit setting names display line, high or low, value, and terminator
// R13 - limit off disables and limit on enables checking for the line
// R14 - controller picks the entry line before limit commands
// R15 - controller sets both limits before enabling checking
// R16 - status byte bit 4 rises on any checked reading outside limits
// R17 - error field reports 21 for over-limit and 23 for under-limit
// R18 - per-line status: 0 within, 1 too high, 2 too low
// R19 - up arrow for over-limit, down arrow for under-limit
// R20 - with sound enabled, high tone over-limit, low tone under-limit
// R21 - sensor selection then limit on checks that sensor against its line
// R22 - every new reading re-evaluates enabled lines, clearing back to within
// R23 - exported trigger digit 0 to 3: hold, single, full average, free run
package lmc_pkg;
  localparam int TEXT_LEN = 118;
  localparam int TEXT_MAX = 128;
  localparam int BIN_LEN = 28;
  localparam int BIN_LEN_LEGACY = 58;
  localparam int BIN_FRAME = BIN_LEN_LEGACY + 2;
  localparam int RD_W_DEF = 24;
  localparam int STB_LIMIT_BIT = 4;
  localparam logic [7:0] ERR_OVER = 8'h15;
  localparam logic [7:0] ERR_UNDER = 8'h17;
  localparam logic [1:0] LST_OK = 2'h0;
  localparam logic [1:0] LST_HIGH = 2'h1;
  localparam logic [1:0] LST_LOW = 2'h2;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  // apb byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_VALUE = 8'h04;
  localparam logic [7:0] A_CTRL = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_LINE = 8'h10;
  localparam logic [7:0] A_ERR = 8'h14;
  localparam logic [7:0] A_CFG = 8'h18;
  localparam int CTRL_SOUND = 0;
  localparam int CTRL_LEGACY = 1;
  localparam int VAL_NEG = 31;
  localparam int ST_BUSY = 8;
  localparam int ST_PEND = 9;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_TEXT_REQ = 5'h01, OP_BIN_REQ = 5'h02, OP_LIM_OFF = 5'h03,
    OP_LIM_ON = 5'h04, OP_CEIL = 5'h05, OP_FLOOR = 5'h06, OP_LINE_PICK = 5'h07,
    OP_MEAS = 5'h08, OP_TRIG = 5'h09, OP_GTRIG = 5'h0a, OP_REF_OUT = 5'h0b,
    OP_UNITS = 5'h0c, OP_CAL = 5'h0d, OP_SHIFT = 5'h0e, OP_SPAN = 5'h0f,
    OP_SMOOTH_AUTO = 5'h10, OP_SMOOTH_MAN = 5'h11, OP_REL = 5'h12
  } lmc_op_t;

  typedef struct packed {
    logic [15:0] cal;
    logic off_neg;
    logic [15:0] off;
    logic [3:0] rng;
    logic fil_man;
    logic [3:0] fil;
  } lmc_sens_t;

  typedef struct packed {
    logic lo_neg;
    logic [23:0] lo;
    logic hi_neg;
    logic [23:0] hi;
  } lmc_lim_t;

  typedef struct packed {
    logic [1:0] trig;
    logic [1:0] gt;
    logic [2:0] meas;
    logic ael;
    logic logu;
    logic refout;
    logic rel;
    logic [15:0] refv;
    lmc_sens_t [1:0] sens;
    lmc_lim_t [1:0] lim;
    logic [1:0] lm_en;
  } lmc_cfg_t;

  typedef struct packed {
    logic [1:0][7:0] sel, kb;
    logic [4:0][7:0] cal;
    logic [1:0][7:0] en1, os;
    logic [5:0][7:0] off;
    logic [1:0][7:0] en2, ra;
    logic [7:0] rng;
    logic [1:0][7:0] en3, fil;
    logic [7:0] fild;
    logic [1:0][7:0] en4, ll;
    logic [7:0][7:0] llv;
    logic [1:0][7:0] en5;
  } lmc_sens_txt_t;

  typedef struct packed {
    logic [1:0][7:0] tr;
    logic [7:0] trigger_setting;
    logic [1:0][7:0] meas;
    lmc_sens_txt_t sa;
    logic [1:0][7:0] lh;
    logic [7:0][7:0] lhv;
    logic [1:0][7:0] en6;
    lmc_sens_txt_t sb;
    logic [1:0][7:0] ael, units, oc;
    logic [7:0] ocd;
    logic [1:0][7:0] gt;
    logic [7:0] group_trigger_setting;
    logic [1:0][7:0] lm;
    logic [7:0] lmd;
    logic [1:0][7:0] crlf;
  } lmc_text_t;

  typedef struct packed {
    logic [7:0] cal_hi, cal_lo, off_sign, off_hi, off_lo, rng, fil;
  } lmc_sens_bin_t;

  typedef struct packed {
    logic [7:0] meas;
    logic [7:0] flags;
    logic [1:0][7:0] refv;
    lmc_sens_bin_t [1:0] sens;
    logic [9:0][7:0] pad;
  } lmc_bin_t;
endpackage : lmc_pkg
